/* hdl/rfconv_defs.svh */
/*
 * Register indexes, field positions and reset values of the
 * resistance-to-frequency converter. Assumes that each index is
 * turned into a byte address four times as large by the bus.
 */
`ifndef RFCONV_DEFS_SVH
`define RFCONV_DEFS_SVH

// Register indexes, byte address is index * 4
`define RFCONV_IDX_W        15
`define RFCONV_IDX_CLK      15'h5067
`define RFCONV_IDX_CTL      15'h53a0
`define RFCONV_IDX_TRIG     15'h53a2
`define RFCONV_IDX_MEAS_LO  15'h53a4
`define RFCONV_IDX_MEAS_HI  15'h53a6
`define RFCONV_IDX_TB_LO    15'h53a8
`define RFCONV_IDX_TB_HI    15'h53aa
`define RFCONV_IDX_MASK     15'h53ac
`define RFCONV_IDX_FLAG     15'h53ae

// Clock control fields and reset
`define RFCONV_CLK_DIV_LSB  4
`define RFCONV_CLK_SRC_BIT  2
`define RFCONV_CLK_GATE_BIT 0
`define RFCONV_CLK_DIV_RST  2'h0
`define RFCONV_CLK_SRC_RST  1'h1

// Control fields
`define RFCONV_CTL_CONT_BIT 7
`define RFCONV_CTL_EVT_BIT  6
`define RFCONV_CTL_EN_BIT   0

// Trigger, flag and mask fields
`define RFCONV_TRG_SENB_BIT 2
`define RFCONV_TRG_SENA_BIT 1
`define RFCONV_TRG_REF_BIT  0
`define RFCONV_FLG_TB_BIT   4
`define RFCONV_FLG_MEAS_BIT 3
`define RFCONV_FLG_W        5
`define RFCONV_CNT_W        24

`endif

/* hdl/rfconv_pkg.sv */
/*
 * Types of the resistance-to-frequency converter.
 * Assumes rfconv_defs.svh is compiled alongside.
 */
package rfconv_pkg;

    // Which oscillation is running
    typedef enum logic [1:0] {
        OSC_IDLE,
        OSC_REF,
        OSC_SENA,
        OSC_SENB
    } rfconv_osc_e;

    // Register and handshake state of the top
    typedef struct packed {
        logic [1:0]  div;
        logic        src;
        logic        gate;
        logic        cont;
        logic        evt;
        logic        en;
        rfconv_osc_e osc;
        logic [4:0]  flag;
        logic [4:0]  mask;
        logic [2:0]  sense;
        logic        ack;
        logic        irq;
        logic [31:0] rdata;
    } rfconv_state_s;

endpackage

/* hdl/rfconv_cnt24.sv */
/*
 * 24-bit up counter written as a 16-bit low and 8-bit high half.
 * Assumes write strobes and increments come from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfconv_defs.svh"

module rfconv_cnt24 (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Software access
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    // Counting
    input  wire logic        inc_i,
    output logic [23:0]      value_o,
    output logic             wrap_o
);
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic        wr_any;

    assign wr_any  = wr_lo_i | wr_hi_i;
    // No wrap reported in a cycle that software overwrites
    assign wrap_o  = inc_i & ~wr_any & (&cnt_q);
    assign value_o = cnt_q;

    // Software write beats a count in the same cycle
    always_comb begin
        cnt_d = cnt_q;
        if (inc_i && !wr_any) begin
            cnt_d = cnt_q + 24'h000001;
        end
        if (wr_lo_i && be_i[0]) begin
            cnt_d[7:0] = wdata_i[7:0];
        end
        if (wr_lo_i && be_i[1]) begin
            cnt_d[15:8] = wdata_i[15:8];
        end
        if (wr_hi_i && be_i[0]) begin
            cnt_d[23:16] = wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 24'h000000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    a_cnt_wrap_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wrap_o |=> (value_o == 24'h000000))
        else $error("counter did not wrap to zero");

endmodule
`default_nettype wire

/* hdl/rfconv_clock_divider_select.sv */
/*
 * Converter count clock: picks a source pin, divides source three,
 * gates, and gives a one-cycle enable pulse. Pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfconv_defs.svh"

module rfconv_clock_divider_select (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Source pins
    input  wire logic       clock_source_one_i,
    input  wire logic       clock_source_three_i,
    // Settings
    input  wire logic       src_sel_i,
    input  wire logic [1:0] div_sel_i,
    input  wire logic       gate_i,
    // Count enable pulse
    output logic            tick_o
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s3;
        logic       l1;
        logic       l3;
        logic [2:0] pre;
        logic       tick;
    } rfconv_div_s;

    rfconv_div_s st_q;
    rfconv_div_s st_d;
    logic        edge1;
    logic        edge3;
    logic [2:0]  mask;

    // Edges read only the second sync stage
    assign edge1 = st_q.s1[1] & ~st_q.l1;
    assign edge3 = st_q.s3[1] & ~st_q.l3;
    assign tick_o = st_q.tick;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = {st_q.s1[0], clock_source_one_i};
        st_d.s3 = {st_q.s3[0], clock_source_three_i};
        st_d.l1 = st_q.s1[1];
        st_d.l3 = st_q.s3[1];
        // Ratio 1/1, 1/2, 1/4, 1/8 on source three only
        unique case (div_sel_i)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
        endcase
        if (edge3) begin
            st_d.pre = st_q.pre + 3'h1;
        end
        st_d.tick = gate_i & (src_sel_i ? edge1
                    : (edge3 && ((st_q.pre & mask) == mask)));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    a_tick_gated: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tick_o |-> $past(gate_i))
        else $error("count tick with clock gate closed");

endmodule
`default_nettype wire

/* hdl/rfconv_top.sv */
/*
 * Resistance-to-frequency converter control, one channel, behind a
 * classic Wishbone slave with 32-bit data. Assumes oscillation and
 * clock source pins are asynchronous and are synchronised here.
 */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rfconv_defs.svh"

// Summary of operation
// - Two-bit divider gives 1/1 to 1/8, only on source three.
// - Source select picks source one when set; gate passes clock.
// - Enable, continuous and event mode bits reset to zero.
// - With enable set, writing a trigger bit starts it; bit reads one while running.
// - Both 24-bit counters split low/high, writable, reset zero.
// - Time base overflow sets flag bit four, cleared by one.
// - In event mode, measurement overflow sets flag bit three, cleared by one.
// - Each finished oscillation sets its done flag, cleared by one.
// - Mask bits enable each cause at the flag bit positions.
module rfconv_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Clock source pins
    input  wire logic        clock_source_one_i,
    input  wire logic        clock_source_three_i,
    // Oscillation circuit
    input  wire logic        osc_sense_i,
    output logic             reference_osc_o,
    output logic             sensor_a_osc_o,
    output logic             sensor_b_osc_o,
    // Interrupt
    output logic             irq_o
);
    rfconv_pkg::rfconv_state_s st_q;
    rfconv_pkg::rfconv_state_s st_d;

    logic [`RFCONV_IDX_W-1:0]  idx;
    logic                      req;
    logic                      hit;
    logic                      wr_fire;
    logic                      wr_clk;
    logic                      wr_ctl;
    logic                      wr_trig;
    logic                      wr_mask;
    logic                      wr_flag;
    logic                      wr_meas_lo;
    logic                      wr_meas_hi;
    logic                      wr_tb_lo;
    logic                      wr_tb_hi;
    logic                      tick;
    logic                      running;
    logic                      sense_edge;
    logic                      meas_inc;
    logic                      tb_inc;
    logic                      meas_wrap;
    logic                      tb_wrap;
    logic [`RFCONV_CNT_W-1:0]  meas_val;
    logic [`RFCONV_CNT_W-1:0]  tb_val;
    logic [2:0]                trig_rd;
    logic [2:0]                done_set;
    logic [`RFCONV_FLG_W-1:0]  flag_set;
    logic [`RFCONV_FLG_W-1:0]  flag_clr;
    logic [31:0]               rd;

    // Bus decode; index sits on address bits 16:2
    assign idx = wb_adr_i[16:2];
    assign req = wb_cyc_i & wb_stb_i;
    assign hit = (wb_adr_i[31:17] == 15'h0000)
               & (wb_adr_i[1:0] == 2'h0);
    // Writes land on the edge where the master sees ack
    assign wr_fire = req & wb_we_i & st_q.ack & hit;

    // Per-register write strobes, lane 0 for 8-bit fields
    assign wr_clk  = wr_fire & wb_sel_i[0]
                   & (idx == `RFCONV_IDX_CLK);
    assign wr_ctl  = wr_fire & wb_sel_i[0]
                   & (idx == `RFCONV_IDX_CTL);
    assign wr_trig = wr_fire & wb_sel_i[0]
                   & (idx == `RFCONV_IDX_TRIG);
    assign wr_mask = wr_fire & wb_sel_i[0]
                   & (idx == `RFCONV_IDX_MASK);
    assign wr_flag = wr_fire & wb_sel_i[0]
                   & (idx == `RFCONV_IDX_FLAG);
    assign wr_meas_lo = wr_fire & (idx == `RFCONV_IDX_MEAS_LO);
    assign wr_meas_hi = wr_fire & (idx == `RFCONV_IDX_MEAS_HI);
    assign wr_tb_lo   = wr_fire & (idx == `RFCONV_IDX_TB_LO);
    assign wr_tb_hi   = wr_fire & (idx == `RFCONV_IDX_TB_HI);

    // Counting only while an oscillation runs
    assign running    = (st_q.osc != rfconv_pkg::OSC_IDLE);
    assign sense_edge = st_q.sense[1] & ~st_q.sense[2];
    assign meas_inc   = running & sense_edge;
    assign tb_inc     = running & tick;

    // Trigger bits read back as running status
    always_comb begin
        trig_rd = 3'h0;
        trig_rd[`RFCONV_TRG_REF_BIT]  =
            (st_q.osc == rfconv_pkg::OSC_REF);
        trig_rd[`RFCONV_TRG_SENA_BIT] =
            (st_q.osc == rfconv_pkg::OSC_SENA);
        trig_rd[`RFCONV_TRG_SENB_BIT] =
            (st_q.osc == rfconv_pkg::OSC_SENB);
    end

    // Event mode has no completion, its wrap is an error
    assign done_set = (meas_wrap && !st_q.evt) ? trig_rd : 3'h0;

    // Flag sources and write-one clears
    always_comb begin
        flag_set = {2'h0, done_set};
        flag_set[`RFCONV_FLG_TB_BIT]   = tb_wrap;
        flag_set[`RFCONV_FLG_MEAS_BIT] =
            meas_wrap & st_q.evt;
        flag_clr = wr_flag ? wb_dat_i[`RFCONV_FLG_W-1:0]
                           : 5'h00;
    end

    // Read multiplexer, reserved bits read zero
    always_comb begin
        rd = 32'h00000000;
        unique case (idx)
            `RFCONV_IDX_CLK: begin
                rd[`RFCONV_CLK_DIV_LSB +: 2] = st_q.div;
                rd[`RFCONV_CLK_SRC_BIT]      = st_q.src;
                rd[`RFCONV_CLK_GATE_BIT]     = st_q.gate;
            end
            `RFCONV_IDX_CTL: begin
                rd[`RFCONV_CTL_CONT_BIT] = st_q.cont;
                rd[`RFCONV_CTL_EVT_BIT]  = st_q.evt;
                rd[`RFCONV_CTL_EN_BIT]   = st_q.en;
            end
            `RFCONV_IDX_TRIG:    rd[2:0]  = trig_rd;
            `RFCONV_IDX_MEAS_LO: rd[15:0] = meas_val[15:0];
            `RFCONV_IDX_MEAS_HI: rd[7:0]  = meas_val[23:16];
            `RFCONV_IDX_TB_LO:   rd[15:0] = tb_val[15:0];
            `RFCONV_IDX_TB_HI:   rd[7:0]  = tb_val[23:16];
            `RFCONV_IDX_MASK:    rd[4:0]  = st_q.mask;
            `RFCONV_IDX_FLAG:    rd[4:0]  = st_q.flag;
            default:             rd       = 32'h00000000;
        endcase
        if (!hit) begin
            rd = 32'h00000000;
        end
    end

    // Next state of registers, oscillation and handshake
    always_comb begin
        st_d = st_q;
        // Sense pin: stage 0 feeds stage 1 only
        st_d.sense = {st_q.sense[1:0], osc_sense_i};
        // Single-cycle ack, dropped the cycle after
        st_d.ack   = req & ~st_q.ack;
        st_d.rdata = (req && !st_q.ack) ? rd : st_q.rdata;
        if (wr_clk) begin
            st_d.div  = wb_dat_i[`RFCONV_CLK_DIV_LSB +: 2];
            st_d.src  = wb_dat_i[`RFCONV_CLK_SRC_BIT];
            st_d.gate = wb_dat_i[`RFCONV_CLK_GATE_BIT];
        end
        if (wr_ctl) begin
            st_d.cont = wb_dat_i[`RFCONV_CTL_CONT_BIT];
            st_d.evt  = wb_dat_i[`RFCONV_CTL_EVT_BIT];
            st_d.en   = wb_dat_i[`RFCONV_CTL_EN_BIT];
        end
        if (wr_mask) begin
            st_d.mask = wb_dat_i[`RFCONV_FLG_W-1:0];
        end
        // A hardware set beats a clear in the same cycle
        st_d.flag = (st_q.flag & ~flag_clr) | flag_set;
        // Oscillation sequencing
        unique case (st_q.osc)
            rfconv_pkg::OSC_IDLE: begin
                // Reference first when several bits are written
                if (wr_trig && st_q.en) begin
                    if (wb_dat_i[`RFCONV_TRG_REF_BIT]) begin
                        st_d.osc = rfconv_pkg::OSC_REF;
                    end else if (wb_dat_i[`RFCONV_TRG_SENA_BIT]) begin
                        st_d.osc = rfconv_pkg::OSC_SENA;
                    end else if (wb_dat_i[`RFCONV_TRG_SENB_BIT]) begin
                        st_d.osc = rfconv_pkg::OSC_SENB;
                    end
                end
            end
            rfconv_pkg::OSC_REF,
            rfconv_pkg::OSC_SENA,
            rfconv_pkg::OSC_SENB: begin
                // Continuous mode keeps oscillating past done
                if (tb_wrap) begin
                    st_d.osc = rfconv_pkg::OSC_IDLE;
                end else if (|done_set && !st_q.cont) begin
                    st_d.osc = rfconv_pkg::OSC_IDLE;
                end
                // Writing zero to the running bit stops it
                if (wr_trig && ((wb_dat_i[2:0] & trig_rd) == 3'h0))
                begin
                    st_d.osc = rfconv_pkg::OSC_IDLE;
                end
            end
        endcase
        if (!st_q.en) begin
            st_d.osc = rfconv_pkg::OSC_IDLE;
        end
        // Registered so the line is glitch free
        st_d.irq = |(st_d.flag & st_d.mask);
    end

    // Single register for all top state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= '0;
            st_q.div  <= `RFCONV_CLK_DIV_RST;
            st_q.src  <= `RFCONV_CLK_SRC_RST;
            st_q.osc  <= rfconv_pkg::OSC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state
    assign wb_ack_o        = st_q.ack;
    assign wb_dat_o        = st_q.rdata;
    assign irq_o           = st_q.irq;
    assign reference_osc_o = (st_q.osc == rfconv_pkg::OSC_REF);
    assign sensor_a_osc_o  = (st_q.osc == rfconv_pkg::OSC_SENA);
    assign sensor_b_osc_o  = (st_q.osc == rfconv_pkg::OSC_SENB);

    // Count clock: source pick, divide and gate
    rfconv_clock_divider_select u_clock_divider_select (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .clock_source_one_i   (clock_source_one_i),
        .clock_source_three_i (clock_source_three_i),
        .src_sel_i            (st_q.src),
        .div_sel_i            (st_q.div),
        .gate_i               (st_q.gate),
        .tick_o               (tick)
    );

    // Measurement counter counts oscillation edges
    rfconv_cnt24 u_meas (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_lo_i (wr_meas_lo),
        .wr_hi_i (wr_meas_hi),
        .be_i    (wb_sel_i[1:0]),
        .wdata_i (wb_dat_i[15:0]),
        .inc_i   (meas_inc),
        .value_o (meas_val),
        .wrap_o  (meas_wrap)
    );

    // Time base counter counts converter clock ticks
    rfconv_cnt24 u_tb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_lo_i (wr_tb_lo),
        .wr_hi_i (wr_tb_hi),
        .be_i    (wb_sel_i[1:0]),
        .wdata_i (wb_dat_i[15:0]),
        .inc_i   (tb_inc),
        .value_o (tb_val),
        .wrap_o  (tb_wrap)
    );

    // Checks on the live behaviour
    a_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_irq_follows: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_o == |(st_q.flag & st_q.mask))
        else $error("irq does not match enabled flags");

    a_mask_gates: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_q.mask == 5'h00) |-> !irq_o)
        else $error("irq raised with all causes masked");

    a_tb_flag_w1c: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_flag && wb_dat_i[`RFCONV_FLG_TB_BIT] && !tb_wrap)
        |=> !st_q.flag[`RFCONV_FLG_TB_BIT])
        else $error("time base flag not cleared by one");

    a_tb_set_wins: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tb_wrap |=> st_q.flag[`RFCONV_FLG_TB_BIT])
        else $error("time base overflow lost");

    a_meas_ovf: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (meas_wrap && st_q.evt)
        |=> st_q.flag[`RFCONV_FLG_MEAS_BIT])
        else $error("measurement overflow not flagged");

    a_ref_done: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (meas_wrap && !st_q.evt
         && st_q.osc == rfconv_pkg::OSC_REF)
        |=> st_q.flag[`RFCONV_TRG_REF_BIT])
        else $error("reference done flag not set");

    a_trig_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_trig && st_q.en && !running
         && wb_dat_i[`RFCONV_TRG_REF_BIT])
        |=> reference_osc_o ##1 (reference_osc_o || !running))
        else $error("reference oscillation did not start");

    a_off_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !st_q.en |=> !running)
        else $error("oscillation runs while disabled");

endmodule
`default_nettype wire

/* verif/rfconv_osc_model.sv */
/*
 * Behavioural far side of the converter: the resistive oscillation
 * circuits and the two free-running clock source pins.
 * Assumes the enables come straight from the converter outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module rfconv_osc_model (
    // Oscillation enables from the converter
    input  wire logic reference_osc_i,
    input  wire logic sensor_a_osc_i,
    input  wire logic sensor_b_osc_i,
    // Pins towards the converter
    output logic      osc_sense_o,
    output logic      clock_source_one_o,
    output logic      clock_source_three_o
);
    // Slow and fast sources, unrelated to the system clock
    initial begin
        clock_source_one_o = 1'b0;
        forever #100 clock_source_one_o = ~clock_source_one_o;
    end
    initial begin
        clock_source_three_o = 1'b0;
        forever #25 clock_source_three_o = ~clock_source_three_o;
    end

    // Oscillates only while one circuit is switched on
    initial begin
        osc_sense_o = 1'b0;
        forever begin
            #40;
            if (reference_osc_i | sensor_a_osc_i | sensor_b_osc_i) begin
                osc_sense_o = ~osc_sense_o;
            end else begin
                osc_sense_o = 1'b0; // Stopped circuit rests low
            end
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
/*
 * Self-checking bench of the converter: register defaults, access,
 * a reference run to completion, a divided time base overflow,
 * event counter mode and continuous oscillation.
 * Assumes the oscillation model in rfconv_osc_model.sv.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfconv_defs.svh"

module testbench;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq;
    logic [31:0] adr, wdat, rdat, q;
    logic        s_one, s_three, sense, ref_o, sa_o, sb_o;
    int          mismatches, checked, cycles;

    rfconv_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .clock_source_one_i(s_one),
        .clock_source_three_i(s_three), .osc_sense_i(sense),
        .reference_osc_o(ref_o), .sensor_a_osc_o(sa_o),
        .sensor_b_osc_o(sb_o), .irq_o(irq)
    );
    rfconv_osc_model u_osc (
        .reference_osc_i(ref_o), .sensor_a_osc_i(sa_o),
        .sensor_b_osc_i(sb_o), .osc_sense_o(sense),
        .clock_source_one_o(s_one), .clock_source_three_o(s_three)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask

    // Classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [14:0] idx,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {15'h0000, idx, 2'b00};
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [14:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        check(q, exp);
    endtask

    // Bounded wait for the interrupt level
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_reset;
        rd(`RFCONV_IDX_CLK, 32'h4);
        rd(`RFCONV_IDX_CTL, 32'h0);
        rd(`RFCONV_IDX_TRIG, 32'h0);
        rd(`RFCONV_IDX_TB_HI, 32'h0);
        rd(`RFCONV_IDX_MASK, 32'h0);
        rd(`RFCONV_IDX_FLAG, 32'h0);
        rd(15'h0001, 32'h0);             // Unmapped reads zero
        check(irq, 1'b0);
    endtask

    // Reserved bits read zero, fields hold what was written
    task automatic t_regs;
        wb(1'b1, `RFCONV_IDX_CTL, 32'hffc0);
        rd(`RFCONV_IDX_CTL, 32'hc0);
        wb(1'b1, `RFCONV_IDX_CTL, 32'h0);
        wb(1'b1, `RFCONV_IDX_CLK, 32'hff);
        rd(`RFCONV_IDX_CLK, 32'h35);
        wb(1'b1, `RFCONV_IDX_MEAS_HI, 32'hffff);
        rd(`RFCONV_IDX_MEAS_HI, 32'hff);
        wb(1'b1, `RFCONV_IDX_TB_LO, 32'h1234);
        rd(`RFCONV_IDX_TB_LO, 32'h1234);
        wb(1'b1, `RFCONV_IDX_MASK, 32'hff);
        rd(`RFCONV_IDX_MASK, 32'h1f);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h0);
    endtask

    // Four sense edges from completion, then mask and clear
    task automatic t_ref;
        wb(1'b1, `RFCONV_IDX_MEAS_LO, 32'hfffc);
        wb(1'b1, `RFCONV_IDX_MEAS_HI, 32'hff);
        wb(1'b1, `RFCONV_IDX_CLK, 32'h05);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h01);
        wb(1'b1, `RFCONV_IDX_CTL, 32'h01);
        wb(1'b1, `RFCONV_IDX_TRIG, 32'h01);
        rd(`RFCONV_IDX_TRIG, 32'h1);
        check(ref_o, 1'b1);
        wait_irq(400);
        check(irq, 1'b1);
        rd(`RFCONV_IDX_FLAG, 32'h01);
        rd(`RFCONV_IDX_TRIG, 32'h0);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0);
        wb(1'b1, `RFCONV_IDX_FLAG, 32'h0);
        rd(`RFCONV_IDX_FLAG, 32'h01);
        wb(1'b1, `RFCONV_IDX_FLAG, 32'h01);
        rd(`RFCONV_IDX_FLAG, 32'h0);
    endtask

    // Source three at 1/8: two ticks take well over 40 cycles
    task automatic t_tb;
        wb(1'b1, `RFCONV_IDX_TB_LO, 32'hfffe);
        wb(1'b1, `RFCONV_IDX_TB_HI, 32'hff);
        wb(1'b1, `RFCONV_IDX_MEAS_LO, 32'h0);
        wb(1'b1, `RFCONV_IDX_MEAS_HI, 32'h0);
        wb(1'b1, `RFCONV_IDX_CLK, 32'h31);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h10);
        wb(1'b1, `RFCONV_IDX_TRIG, 32'h02);
        // Start lands on the ack edge, output shows a cycle later
        @(posedge clk_i);
        check(sa_o, 1'b1);
        repeat (40) @(posedge clk_i);
        check(irq, 1'b0);
        wait_irq(400);
        check(irq, 1'b1);
        rd(`RFCONV_IDX_FLAG, 32'h10);
        check(sa_o, 1'b0);
        wb(1'b1, `RFCONV_IDX_FLAG, 32'h10);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0);
    endtask

    // Event mode on sensor B keeps running, then continuous reference
    task automatic t_modes;
        wb(1'b1, `RFCONV_IDX_MEAS_LO, 32'hfffe);
        wb(1'b1, `RFCONV_IDX_MEAS_HI, 32'hff);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h08);
        wb(1'b1, `RFCONV_IDX_CTL, 32'h41);
        wb(1'b1, `RFCONV_IDX_TRIG, 32'h04);
        wait_irq(400);
        rd(`RFCONV_IDX_FLAG, 32'h08);
        check(sb_o, 1'b1);
        wb(1'b1, `RFCONV_IDX_TRIG, 32'h0);
        rd(`RFCONV_IDX_TRIG, 32'h0);
        check(sb_o, 1'b0);
        wb(1'b1, `RFCONV_IDX_FLAG, 32'h08);
        wb(1'b1, `RFCONV_IDX_MEAS_LO, 32'hfffe);
        wb(1'b1, `RFCONV_IDX_MEAS_HI, 32'hff);
        wb(1'b1, `RFCONV_IDX_MASK, 32'h01);
        wb(1'b1, `RFCONV_IDX_CTL, 32'h81);
        wb(1'b1, `RFCONV_IDX_TRIG, 32'h01);
        wait_irq(400);
        rd(`RFCONV_IDX_FLAG, 32'h01);
        check(ref_o, 1'b1);
        wb(1'b1, `RFCONV_IDX_CTL, 32'h0);
        rd(`RFCONV_IDX_TRIG, 32'h0);
        wb(1'b1, `RFCONV_IDX_FLAG, 32'h01);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we} = 3'b000;
        adr  = 32'h0;
        wdat = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_ref();
        t_tb();
        t_modes();
        report_and_stop();
    end
endmodule
`default_nettype wire
